//--- logic/acir_pkg.sv
// constants, types and register map of the accelerometer control and irq registers
// assumes a 25 MHz core clock shared by the host port and the sensing core
package acir_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  // slowest wake evaluation rate, in millihertz
  localparam int unsigned WAKE_RATE_MIN_MHZ = 781;
  localparam int unsigned WAKE_BASE_CYCLES =
    int'((longint'(CLK_HZ) * 1000) / WAKE_RATE_MIN_MHZ);
  // irq pulse width, least time rounded up
  localparam int unsigned IRQ_PULSE_MIN_NS = 30_000;
  localparam int unsigned IRQ_PULSE_MAX_NS = 50_000;
  localparam int unsigned IRQ_PULSE_CYCLES =
    (IRQ_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] ADDR_SELFTEST_RESP = 8'h0c;
  localparam logic [7:0] ADDR_DIR_SRC = 8'h17;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_RELEASE = 8'h1a;
  localparam logic [7:0] ADDR_MAIN = 8'h1b;
  localparam logic [7:0] ADDR_SEC = 8'h1d;
  localparam logic [7:0] ADDR_PIN = 8'h1e;
  localparam logic [7:0] ADDR_DIR_EN = 8'h1f;

  // ==========================================================================
  // reset values and writable masks
  localparam logic [7:0] MAIN_RST = 8'h00;
  localparam logic [7:0] MAIN_WR_MASK = 8'hfa;
  localparam logic [2:0] SEC_RATE_RST = 3'h0;
  localparam logic [7:0] PIN_RST = 8'h10;
  localparam logic [7:0] PIN_WR_MASK = 8'h38;
  localparam logic [5:0] DIR_EN_RST = 6'h3f;
  localparam logic [7:0] SELFTEST_IDLE = 8'h55;
  localparam logic [7:0] SELFTEST_FORCED = 8'haa;

  // ==========================================================================
  // field positions
  localparam int unsigned MAIN_RUN_BIT = 7;
  localparam int unsigned MAIN_PERF_BIT = 6;
  localparam int unsigned MAIN_NEWS_BIT = 5;
  localparam int unsigned MAIN_RANGE_LSB = 3;
  localparam int unsigned MAIN_WAKE_BIT = 1;
  localparam int unsigned SEC_REBOOT_BIT = 7;
  localparam int unsigned SEC_SELFTEST_BIT = 4;
  localparam int unsigned PIN_ON_BIT = 5;
  localparam int unsigned PIN_POL_BIT = 4;
  localparam int unsigned PIN_PULSE_BIT = 3;
  localparam int unsigned STATUS_INT_BIT = 4;

  // ==========================================================================
  // types
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acir_bus_type;

  typedef enum logic [1:0] {
    RANGE_2G = 2'b00,
    RANGE_4G = 2'b01,
    RANGE_8G = 2'b10,
    RANGE_8G_EXT = 2'b11
  } acir_range_type;

  typedef enum logic [1:0] {
    PIN_IDLE = 2'b00,
    PIN_PULSE = 2'b01,
    PIN_LATCH = 2'b10,
    PIN_SPENT = 2'b11
  } acir_pin_state_type;

endpackage

//--- logic/acir_wake.sv
// wake-up engine: rate divider and motion persistence counter
// assumes masked motion levels come from the sensing core on the same clock
`timescale 1ns/100ps
module acir_wake
  import acir_pkg::*;
#(
  parameter int unsigned p_base_cycles = WAKE_BASE_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_run,
  input wire logic [2:0] i_rate,
  input wire logic [7:0] i_count,
  input wire logic [5:0] i_motion,
  output logic o_event,
  output logic [5:0] o_dir
);

  logic [25:0] div_q, div_d;
  logic [7:0] pers_q, pers_d;
  logic fired_q, fired_d;
  logic evt_q, evt_d;
  logic [5:0] dir_q, dir_d;
  logic [25:0] period;
  logic tick;
  logic [7:0] need;

  // ==========================================================================
  // evaluation rate and persistence
  always_comb begin
    period = 26'(p_base_cycles >> i_rate); // RULE15
    tick = (div_q >= period - 26'h1);
    need = (i_count == 8'h00) ? 8'h01 : i_count;
    div_d = tick ? 26'h0 : div_q + 26'h1;
    pers_d = pers_q;
    fired_d = fired_q;
    evt_d = 1'b0;
    dir_d = dir_q;
    if (!i_run) begin
      div_d = 26'h0;
      pers_d = 8'h00;
      fired_d = 1'b0;
    end else if (tick) begin
      if (|i_motion) begin
        if (!fired_q) begin
          pers_d = pers_q + 8'h01;
          if (pers_q + 8'h01 >= need) begin // RULE22
            evt_d = 1'b1;
            fired_d = 1'b1;
            dir_d = i_motion;
          end
        end
      end else begin
        pers_d = 8'h00;
        fired_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_q <= 26'h0;
      pers_q <= 8'h00;
      fired_q <= 1'b0;
      evt_q <= 1'b0;
      dir_q <= 6'h00;
    end else begin
      div_q <= div_d;
      pers_q <= pers_d;
      fired_q <= fired_d;
      evt_q <= evt_d;
      dir_q <= dir_d;
    end
  end

  assign o_event = evt_q;
  assign o_dir = dir_q;

  AST_WAKE_NEEDS_RUN: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !$past(i_run) |-> !o_event) else $error("wake event while engine off"); // RULE22

endmodule

//--- logic/acir_pin.sv
// physical interrupt pin driver: latched or one pulse, selectable polarity
// assumes event and release are one-cycle pulses on the core clock
`timescale 1ns/100ps
module acir_pin
  import acir_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_event,
  input wire logic i_release,
  input wire logic i_on,
  input wire logic i_pol,
  input wire logic i_pulse_mode,
  output logic o_pin
);

  acir_pin_state_type state_q, state_d;
  logic [10:0] cnt_q, cnt_d;
  logic pin_q, pin_d;
  logic active;

  // ==========================================================================
  // pin state machine
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      PIN_IDLE: begin
        cnt_d = 11'h000;
      end
      PIN_PULSE: begin
        cnt_d = cnt_q + 11'h001;
        if (cnt_q == 11'(IRQ_PULSE_CYCLES - 1)) begin // RULE18
          state_d = PIN_SPENT;
        end
      end
      PIN_LATCH: begin
        cnt_d = 11'h000;
      end
      PIN_SPENT: begin
        cnt_d = 11'h000;
      end
      default: begin
        state_d = PIN_IDLE;
        cnt_d = 11'h000;
      end
    endcase
    if (i_release) begin // RULE18
      state_d = PIN_IDLE;
      cnt_d = 11'h000;
    end
    if (i_event && (state_q == PIN_IDLE || i_release)) begin // RULE23
      state_d = i_pulse_mode ? PIN_PULSE : PIN_LATCH;
      cnt_d = 11'h000;
    end
    active = i_on && (state_d == PIN_PULSE || state_d == PIN_LATCH); // RULE16
    pin_d = active ? i_pol : ~i_pol; // RULE17
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= PIN_IDLE;
      cnt_q <= 11'h000;
      pin_q <= PIN_RST[PIN_POL_BIT] ? 1'b0 : 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pin_q <= pin_d;
    end
  end

  assign o_pin = pin_q;

  AST_PULSE_WIDTH: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state_q == PIN_IDLE && i_event && i_pulse_mode && !i_release)
    |=> (state_q == PIN_PULSE) [*8])
    else $error("irq pulse shorter than expected"); // RULE18

endmodule

//--- logic/acir_regs.sv
// control and interrupt register bank of a three-axis accelerometer
// assumes a serial slave front end that gives one-cycle read and write strobes
// How it works
// [RULE1] motion source: six direction flags, top bits zero
// [RULE2] release read clears all direction flags
// [RULE3] status bit 4 shows combined source flag
// [RULE4] data read or release read clears status
// [RULE5] release read clears sources and pin
// [RULE6] main bit 7 selects standby or run
// [RULE7] main bit 6 selects low or high current
// [RULE8] main bit 5 lets new samples interrupt
// [RULE9] main bits 4:3 select full scale range
// [RULE10] range 11 gives 14-bit only at full power
// [RULE11] main bit 1 enables motion wake function
// [RULE12] host enters standby before changing settings
// [RULE13] reboot bit reads one until reboot done
// [RULE14] self-test bit forces response aa until read
// [RULE15] secondary bits 2:0 set wake evaluation rate
// [RULE16] pin control bit 5 enables the pin
// [RULE17] pin control bit 4 sets pin polarity
// [RULE18] pin control bit 3 selects latch or pulse
// [RULE19] direction enables gate motion, reset all on
// [RULE20] new sample flag set on data, read-cleared
// [RULE21] wake flag set on motion, release-cleared
// [RULE22] wake fires after motion persists programmed count
// [RULE23] enabled pin asserts when status becomes set; in pulse mode it pulses once, then stays inactive until a release read
`timescale 1ns/100ps
module acir_regs
  import acir_pkg::*;
#(
  parameter int unsigned p_wake_base_cycles = WAKE_BASE_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire acir_bus_type i_bus,
  input wire logic i_sample_new,
  input wire logic i_out_data_rd,
  input wire logic [5:0] i_motion,
  input wire logic [7:0] i_wake_count,
  input wire logic i_reboot_done,
  output logic [7:0] o_rdata,
  output logic o_run,
  output logic o_perf_high,
  output logic [1:0] o_range,
  output logic o_ext_res,
  output logic o_wake_on,
  output logic [2:0] o_wake_rate,
  output logic o_reboot_busy,
  output logic o_irq_pin
);

  // ==========================================================================
  // address decode
  function automatic logic hit(input acir_bus_type bus, input logic [7:0] off);
    hit = (bus.addr == off);
  endfunction

  logic [7:0] main_q, main_d;
  logic reboot_q, reboot_d;
  logic selftest_q, selftest_d;
  logic [2:0] rate_q, rate_d;
  logic [7:0] pin_q, pin_d;
  logic [5:0] dir_en_q, dir_en_d;
  logic new_q, new_d;
  logic wake_q, wake_d;
  logic [5:0] dir_q, dir_d;
  logic status_q, status_d;
  logic [7:0] rdata_q, rdata_d;
  logic ext_q, ext_d;
  logic wr_main, wr_sec, wr_pin, wr_dir_en;
  logic rd_release, rd_selftest, data_rd;
  logic new_set, status_set;
  logic wake_evt;
  logic [5:0] wake_dir;
  logic [5:0] dir_set;
  logic [5:0] motion_gated;
  logic wake_run;

  // ==========================================================================
  // strobes
  always_comb begin
    wr_main = i_bus.wr && hit(i_bus, ADDR_MAIN);
    wr_sec = i_bus.wr && hit(i_bus, ADDR_SEC);
    wr_pin = i_bus.wr && hit(i_bus, ADDR_PIN);
    wr_dir_en = i_bus.wr && hit(i_bus, ADDR_DIR_EN);
    rd_release = i_bus.rd && hit(i_bus, ADDR_RELEASE);
    rd_selftest = i_bus.rd && hit(i_bus, ADDR_SELFTEST_RESP);
    data_rd = i_out_data_rd;
  end

  // ==========================================================================
  // wake-up engine
  assign wake_run = main_q[MAIN_RUN_BIT] && main_q[MAIN_WAKE_BIT]; // RULE11
  assign motion_gated = i_motion & dir_en_q; // RULE19

  acir_wake #(
    .p_base_cycles(p_wake_base_cycles)
  ) u_wake (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_run(wake_run),
    .i_rate(rate_q),
    .i_count(i_wake_count),
    .i_motion(motion_gated),
    .o_event(wake_evt),
    .o_dir(wake_dir)
  );

  // ==========================================================================
  // direction flags, one per axis and sign
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_dir
      assign dir_set[gi] = wake_evt && wake_dir[gi];
      // set wins over the release read
      assign dir_d[gi] = dir_set[gi] || (dir_q[gi] && !rd_release); // RULE2
    end
  endgenerate

  // ==========================================================================
  // control and source next state
  always_comb begin
    main_d = main_q;
    reboot_d = reboot_q;
    selftest_d = selftest_q;
    rate_d = rate_q;
    pin_d = pin_q;
    dir_en_d = dir_en_q;
    if (wr_main) begin
      main_d = i_bus.wdata & MAIN_WR_MASK; // RULE6
    end
    if (i_reboot_done) begin
      reboot_d = 1'b0;
    end
    if (wr_sec && i_bus.wdata[SEC_REBOOT_BIT]) begin
      reboot_d = 1'b1; // RULE13
    end
    if (rd_selftest) begin
      selftest_d = 1'b0;
    end
    if (wr_sec && i_bus.wdata[SEC_SELFTEST_BIT]) begin
      selftest_d = 1'b1; // RULE14
    end
    if (wr_sec) begin
      rate_d = i_bus.wdata[2:0]; // RULE15
    end
    if (wr_pin) begin
      pin_d = i_bus.wdata & PIN_WR_MASK; // RULE16
    end
    if (wr_dir_en) begin
      dir_en_d = i_bus.wdata[5:0]; // RULE19
    end
    new_set = i_sample_new && main_q[MAIN_RUN_BIT] && main_q[MAIN_NEWS_BIT]; // RULE8
    new_d = new_set || (new_q && !data_rd && !rd_release); // RULE20
    wake_d = wake_evt || (wake_q && !rd_release); // RULE21
    status_set = new_set || wake_evt;
    status_d = status_set || (status_q && !data_rd && !rd_release); // RULE4
    ext_d = main_d[MAIN_PERF_BIT] &&
      (main_d[MAIN_RANGE_LSB +: 2] == RANGE_8G_EXT); // RULE10
  end

  // ==========================================================================
  // read mux
  always_comb begin
    rdata_d = rdata_q;
    if (i_bus.rd) begin
      case (i_bus.addr)
        ADDR_SELFTEST_RESP: rdata_d = selftest_q ? SELFTEST_FORCED : SELFTEST_IDLE; // RULE14
        ADDR_DIR_SRC: rdata_d = {2'b00, dir_q}; // RULE1
        ADDR_STATUS: rdata_d = 8'(status_q) << STATUS_INT_BIT; // RULE3
        ADDR_RELEASE: rdata_d = 8'h00; // RULE5
        ADDR_MAIN: rdata_d = main_q;
        ADDR_SEC: rdata_d = {reboot_q, 2'b00, selftest_q, 1'b0, rate_q};
        ADDR_PIN: rdata_d = pin_q;
        ADDR_DIR_EN: rdata_d = {2'b00, dir_en_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      main_q <= MAIN_RST;
      reboot_q <= 1'b0;
      selftest_q <= 1'b0;
      rate_q <= SEC_RATE_RST;
      pin_q <= PIN_RST;
      dir_en_q <= DIR_EN_RST;
      new_q <= 1'b0;
      wake_q <= 1'b0;
      dir_q <= 6'h00;
      status_q <= 1'b0;
      rdata_q <= 8'h00;
      ext_q <= 1'b0;
    end else begin
      main_q <= main_d;
      reboot_q <= reboot_d;
      selftest_q <= selftest_d;
      rate_q <= rate_d;
      pin_q <= pin_d;
      dir_en_q <= dir_en_d;
      new_q <= new_d;
      wake_q <= wake_d;
      dir_q <= dir_d;
      status_q <= status_d;
      rdata_q <= rdata_d;
      ext_q <= ext_d;
    end
  end

  // ==========================================================================
  // interrupt pin
  acir_pin u_pin (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_event(status_set),
    .i_release(rd_release),
    .i_on(pin_q[PIN_ON_BIT]),
    .i_pol(pin_q[PIN_POL_BIT]),
    .i_pulse_mode(pin_q[PIN_PULSE_BIT]),
    .o_pin(o_irq_pin)
  );

  // ==========================================================================
  // outputs
  assign o_rdata = rdata_q;
  assign o_run = main_q[MAIN_RUN_BIT];
  assign o_perf_high = main_q[MAIN_PERF_BIT]; // RULE7
  assign o_range = main_q[MAIN_RANGE_LSB +: 2]; // RULE9
  assign o_ext_res = ext_q;
  assign o_wake_on = main_q[MAIN_WAKE_BIT];
  assign o_wake_rate = rate_q;
  assign o_reboot_busy = reboot_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  AST_DIR_TOP_ZERO: assert property (i_bus.rd && hit(i_bus, ADDR_DIR_SRC)
    |=> o_rdata[7:6] == 2'b00) else $error("direction source top bits set"); // RULE1
  AST_DIR_RELEASE: assert property (rd_release && !wake_evt |=> dir_q == 6'h00)
    else $error("direction flags survive release read"); // RULE2
  AST_STATUS_SET: assert property (status_set |=> status_q ##0 (i_bus.rd &&
    hit(i_bus, ADDR_STATUS)) |=> o_rdata == 8'h10 || !$past(status_q))
    else $error("status bit not reported"); // RULE3
  AST_STATUS_CLEAR: assert property ((data_rd || rd_release) && !status_set
    |=> !status_q) else $error("status not cleared by read"); // RULE4
  AST_RELEASE_ALL: assert property (rd_release && !status_set
    |=> !new_q && !wake_q ##1 o_irq_pin == !pin_q[PIN_POL_BIT])
    else $error("release read left sources or pin active"); // RULE5
  AST_RUN_WRITE: assert property (wr_main |=> o_run == $past(i_bus.wdata[7]))
    else $error("run select not taken from write"); // RULE6
  AST_EXT_RES: assert property (wr_main |=> o_ext_res ==
    ($past(i_bus.wdata[6]) && $past(i_bus.wdata[4:3]) == 2'b11))
    else $error("extended resolution wrong"); // RULE10
  AST_NEWS_GATE: assert property (i_sample_new && !main_q[MAIN_NEWS_BIT] && !new_q
    |=> !new_q) else $error("new sample flagged while not allowed"); // RULE8
  AST_REBOOT_BUSY: assert property ((wr_sec && i_bus.wdata[7]) ||
    (o_reboot_busy && !i_reboot_done) |=> o_reboot_busy)
    else $error("reboot bit dropped early"); // RULE13
  AST_SELFTEST: assert property (selftest_q && rd_selftest && !wr_sec
    |=> o_rdata == 8'haa && !selftest_q) else $error("self-test response wrong"); // RULE14
  AST_WAKE_FLAG: assert property (wake_evt |=> wake_q && status_q)
    else $error("wake event not latched"); // RULE21
  AST_PIN_RISE: assert property (status_set && pin_q[PIN_ON_BIT] && !rd_release &&
    u_pin.state_q != PIN_SPENT
    |=> o_irq_pin == pin_q[PIN_POL_BIT]) else $error("pin not asserted"); // RULE23

endmodule

//--- testbench/acir_host.sv
// host side model: byte writes and reads on the register port
// assumes the bench calls its tasks; drives at the falling clock edge
`timescale 1ns/100ps
module acir_host
  import acir_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic [7:0] i_rdata,
  output acir_bus_type o_bus
);
  // ==========
  // bus cycles
  initial o_bus = '0;

  // idle address and data show the inverse of the last ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_bus = '{1'b1, 1'b0, a, d};
    @(negedge i_core_clk);
    o_bus = '{1'b0, 1'b0, ~a, ~d};
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_core_clk);
    o_bus = '{1'b0, 1'b1, a, 8'h00};
    @(negedge i_core_clk);
    o_bus = '{1'b0, 1'b0, ~a, 8'hff};
    @(negedge i_core_clk);
    d = i_rdata;
  endtask

  // standby first, then change a setting
  task automatic cfg(input logic [7:0] a, input logic [7:0] d);
    wr(ADDR_MAIN, 8'h00);
    wr(a, d);
  endtask
endmodule

//--- testbench/tb_accel_irq_and_control_regs.sv
// self-checking bench for the control and irq register bank
// assumes the host model drives the register port at the falling edge
`timescale 1ns/100ps
module tb_accel_irq_and_control_regs
  import acir_pkg::*;
;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } acir_row_type;

  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  acir_bus_type bus;
  logic sample_new = 1'b0;
  logic data_rd = 1'b0;
  logic [5:0] motion = 6'h00;
  logic [7:0] wake_count = 8'h03;
  logic reboot_done = 1'b0;
  logic [7:0] rdata;
  logic run, perf, ext_res, wake_on, busy, pin;
  logic [1:0] rng;
  logic [2:0] rate;
  logic [7:0] mo;
  int miscompares = 0;
  int n_checks = 0;

  assign mo = {run, perf, rng, ext_res, wake_on, 2'b00};

  always #20 core_clk = ~core_clk;

  acir_regs #(.p_wake_base_cycles(1024)) i_dut (
    .i_core_clk(core_clk),
    .i_rst_b(rst_b),
    .i_bus(bus),
    .i_sample_new(sample_new),
    .i_out_data_rd(data_rd),
    .i_motion(motion),
    .i_wake_count(wake_count),
    .i_reboot_done(reboot_done),
    .o_rdata(rdata),
    .o_run(run),
    .o_perf_high(perf),
    .o_range(rng),
    .o_ext_res(ext_res),
    .o_wake_on(wake_on),
    .o_wake_rate(rate),
    .o_reboot_busy(busy),
    .o_irq_pin(pin)
  );

  acir_host i_host (
    .i_core_clk(core_clk),
    .i_rdata(rdata),
    .o_bus(bus)
  );

  // ==========
  // register table: write flag, address, data, expected read
  acir_row_type rows [20] = '{
    '{1'b0, ADDR_MAIN, 8'h00, 8'h00},
    '{1'b0, ADDR_SEC, 8'h00, 8'h00},
    '{1'b0, ADDR_PIN, 8'h00, 8'h10},
    '{1'b0, ADDR_DIR_EN, 8'h00, 8'h3f},
    '{1'b0, ADDR_DIR_SRC, 8'h00, 8'h00},
    '{1'b0, ADDR_STATUS, 8'h00, 8'h00},
    '{1'b0, ADDR_SELFTEST_RESP, 8'h00, 8'h55},
    '{1'b0, ADDR_RELEASE, 8'h00, 8'h00},
    '{1'b0, 8'h05, 8'h00, 8'h00},
    '{1'b1, ADDR_PIN, 8'hff, 8'h38},
    '{1'b1, ADDR_DIR_EN, 8'hff, 8'h3f},
    '{1'b1, ADDR_SEC, 8'h05, 8'h05},
    '{1'b1, ADDR_DIR_SRC, 8'hff, 8'h00},
    '{1'b1, ADDR_STATUS, 8'hff, 8'h00},
    '{1'b1, 8'h20, 8'hff, 8'h00},
    '{1'b1, ADDR_MAIN, 8'h7f, 8'h7a},
    '{1'b1, ADDR_MAIN, 8'h00, 8'h00},
    '{1'b1, ADDR_PIN, 8'h10, 8'h10},
    '{1'b1, ADDR_DIR_EN, 8'h3f, 8'h3f},
    '{1'b1, ADDR_SEC, 8'h00, 8'h00}
  };

  // ==========
  // helpers
  task automatic results();
    if (miscompares == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask

  task automatic cp(input logic e);
    chk("irq_pin", {7'h00, e}, {7'h00, pin});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask

  task automatic wait_pin(input logic lvl, input int lim);
    int n;
    n = 0;
    while (pin !== lvl && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    if (pin !== lvl) begin
      miscompares++;
      $display("FAIL irq_pin wait expected %b seen %b", lvl, pin);
      results();
    end
  endtask

  // ==========
  // main sequence
  initial begin
    int n;
    cyc(5);
    rst_b = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w)
        i_host.cfg(rows[i].a, rows[i].d);
      rc(rows[i].a, rows[i].e);
    end
    for (int r = 0; r < 4; r++) begin
      i_host.wr(ADDR_MAIN, {3'b010, 2'(r), 3'b000});
      cyc(2);
      chk("main_out", {2'b01, 2'(r), r == 3, 3'b000}, mo);
    end
    i_host.wr(ADDR_MAIN, 8'h18);
    cyc(2);
    chk("main_out", 8'h30, mo);
    i_host.wr(ADDR_MAIN, 8'hda);
    cyc(2);
    chk("main_out", 8'hfc, mo);
    for (int k = 0; k < 8; k++) begin
      i_host.cfg(ADDR_SEC, 8'(k));
      cyc(1);
      chk("wake_rate", 8'(k), {5'h00, rate});
    end
    // latched, active high, new sample source
    i_host.cfg(ADDR_PIN, 8'h30);
    i_host.cfg(ADDR_MAIN, 8'h80);
    pulse(sample_new);
    cyc(4);
    cp(1'b0);
    rc(ADDR_STATUS, 8'h00);
    i_host.cfg(ADDR_MAIN, 8'ha0);
    pulse(sample_new);
    wait_pin(1'b1, 8);
    rc(ADDR_STATUS, 8'h10);
    pulse(data_rd);
    rc(ADDR_STATUS, 8'h00);
    cp(1'b1);
    rc(ADDR_RELEASE, 8'h00);
    cyc(1);
    cp(1'b0);
    // active low, then pin disabled
    i_host.cfg(ADDR_PIN, 8'h20);
    i_host.cfg(ADDR_MAIN, 8'ha0);
    cyc(2);
    cp(1'b1);
    pulse(sample_new);
    wait_pin(1'b0, 8);
    rc(ADDR_RELEASE, 8'h00);
    wait_pin(1'b1, 4);
    i_host.cfg(ADDR_PIN, 8'h10);
    i_host.cfg(ADDR_MAIN, 8'ha0);
    pulse(sample_new);
    cyc(4);
    cp(1'b0);
    rc(ADDR_STATUS, 8'h10);
    rc(ADDR_RELEASE, 8'h00);
    // single pulse mode
    i_host.cfg(ADDR_PIN, 8'h38);
    i_host.cfg(ADDR_MAIN, 8'ha0);
    pulse(sample_new);
    wait_pin(1'b1, 8);
    n = 0;
    while (pin === 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    chk("pulse_ok", 8'h01, {7'h00, n >= 750 && n <= 1250});
    pulse(sample_new);
    cyc(10);
    cp(1'b0);
    rc(ADDR_RELEASE, 8'h00);
    pulse(sample_new);
    wait_pin(1'b1, 8);
    cyc(10);
    rc(ADDR_RELEASE, 8'h00);
    // motion wake, every direction, count of three ticks
    i_host.cfg(ADDR_PIN, 8'h30);
    i_host.cfg(ADDR_SEC, 8'h07);
    i_host.cfg(ADDR_MAIN, 8'h82);
    for (int k = 0; k < 6; k++) begin
      motion = 6'(1 << k);
      cyc(3);
      cp(1'b0);
      wait_pin(1'b1, 40);
      motion = 6'h00;
      rc(ADDR_DIR_SRC, 8'(1 << k));
      rc(ADDR_STATUS, 8'h10);
      rc(ADDR_RELEASE, 8'h00);
      rc(ADDR_DIR_SRC, 8'h00);
      rc(ADDR_STATUS, 8'h00);
    end
    i_host.cfg(ADDR_DIR_EN, 8'h1f);
    i_host.cfg(ADDR_MAIN, 8'h82);
    motion = 6'h20;
    cyc(40);
    cp(1'b0);
    i_host.cfg(ADDR_DIR_EN, 8'h3f);
    i_host.cfg(ADDR_MAIN, 8'h80);
    motion = 6'h3f;
    cyc(40);
    cp(1'b0);
    motion = 6'h00;
    // self-test response and reboot
    i_host.cfg(ADDR_SEC, 8'h10);
    rc(ADDR_SELFTEST_RESP, 8'haa);
    rc(ADDR_SELFTEST_RESP, 8'h55);
    rc(ADDR_SEC, 8'h00);
    i_host.cfg(ADDR_SEC, 8'h80);
    cyc(1);
    chk("reboot_busy", 8'h01, {7'h00, busy});
    rc(ADDR_SEC, 8'h80);
    pulse(reboot_done);
    rc(ADDR_SEC, 8'h00);
    chk("reboot_busy", 8'h00, {7'h00, busy});
    // reset in mid-run
    i_host.cfg(ADDR_PIN, 8'h38);
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    rc(ADDR_PIN, 8'h10);
    rc(ADDR_DIR_EN, 8'h3f);
    rc(ADDR_MAIN, 8'h00);
    cp(1'b0);
    results();
  end
endmodule
